// ### hdl/idedec_pkg.sv
package idedec_pkg;
    // -------------------------------------------------------------------
    // host i/o address ranges
    // -------------------------------------------------------------------
    localparam logic [9:0] CMD_PRI_BASE  = 10'h1f0;  // primary command block
    localparam logic [9:0] CMD_SEC_BASE  = 10'h170;  // secondary command block
    localparam logic [9:0] CTRL_PRI_LO   = 10'h3f6;  // primary control block
    localparam logic [9:0] CTRL_PRI_HI   = 10'h3f7;
    localparam logic [9:0] CTRL_SEC_LO   = 10'h376;  // secondary control block
    localparam logic [9:0] CTRL_SEC_HI   = 10'h377;
    localparam int         CMD_MASK_BITS = 3;        // eight registers per block
    localparam int         CTRL_MASK_BITS = 1;       // two registers per control block

    // -------------------------------------------------------------------
    // configuration bit positions and reset values
    // -------------------------------------------------------------------
    localparam int         FUNC_ACK_BIT  = 1;        // shared pin function bit
    localparam int         ALT_WIDE_BIT  = 2;        // wide select pin function bit
    localparam logic       IDE_EN_RST    = 1'b0;
    localparam logic       SEC_SEL_RST   = 1'b0;
    localparam logic       ACK_MODE_RST  = 1'b0;     // shared pin starts as identity strap
    localparam logic       WIDE_PIN_RST  = 1'b0;     // wide select ignored in reset, then honored while alternate setup bit 2 is clear
    localparam logic       POL_RST       = 1'b1;     // density polarity default
    localparam logic       SEL_N_RST     = 1'b1;     // chip selects idle high
    localparam logic       LATCH_N_RST   = 1'b1;     // latch enables idle high
    localparam logic       D7_RST        = 1'b0;     // bit 7 paths idle low, undriven
    localparam logic       DENS_RST      = 1'b0;
    localparam logic       ACK_N_RST     = 1'b1;

    // -------------------------------------------------------------------
    // strap capture sequencer
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        IDEDEC_ST_RESET = 2'b00,
        IDEDEC_ST_LATCH = 2'b01,
        IDEDEC_ST_RUN   = 2'b11
    } idedec_state_t;
endpackage : idedec_pkg

// ### hdl/idedec_decode.sv
`timescale 1ns/1ps
// combinational window match: base to base + 2**mask_bits - 1
module idedec_decode #(
    parameter int         MASK_BITS = 3,
    parameter logic [9:0] BASE      = 10'h000
) (
    // address
    input  wire logic [9:0] addr,
    // result
    output logic            hit
);
    // compare the upper address bits only
    assign hit = (addr[9:MASK_BITS] == BASE[9:MASK_BITS]);
endmodule : idedec_decode

// ### hdl/idedec_top.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Behaviour
// - primary base: 1f0h-1f7h asserts command select
// - secondary base: 170h-177h asserts command select
// - primary base: 3f6h/3f7h asserts control select
// - secondary base: 376h/377h asserts control select
// - disabled interface keeps both selects inactive
// - disabled interface keeps latch enables inactive
// - any drive access enables low byte latch
// - high byte latch only with wide select
// - bit 7 carried on command and 3f6h/376h
// - bit 7 pin floats at 3f7h/377h
// - function bit picks dma ack or identity
// - dma ack mode forces identity one, active high
// - identity level after reset sets density polarity
// --------------------------------------------------------------------------
module idedec_top (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // host i/o cycle
    input  wire logic [9:0] host_addr,
    input  wire logic       host_rd_n,
    input  wire logic       host_wr_n,
    input  wire logic       host_d7_out,
    input  wire logic       host_d7_oe,
    output logic            host_d7_in,
    // configuration bits
    input  wire logic       ide_enable,
    input  wire logic       secondary_base,
    input  wire logic [7:0] function_ctrl_reg,
    input  wire logic [7:0] alternate_setup_reg,
    input  wire logic       fast_rate,
    // drive side
    input  wire logic       wide_transfer_select_in_n,
    input  wire logic       drive_dma_ack_in,
    input  wire logic       drive_data_bit7_in,
    output logic            drive_data_bit7_out,
    output logic            drive_data_bit7_oe,
    output logic            drive_cmd_block_select_n,
    output logic            drive_ctrl_block_select_n,
    output logic            low_byte_latch_en_n,
    output logic            high_byte_latch_en_n,
    // floppy density and dma ack
    output logic            density_select_out,
    output logic            ide_dma_ack_n
);
    // ----------------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------------
    // registered copies of the configuration ports
    logic ide_en_q;
    logic sec_q;
    logic ack_mode_q;
    logic wide_pin_q;

    // latch configuration bits into the device
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ide_en_q   <= idedec_pkg::IDE_EN_RST;
            sec_q      <= idedec_pkg::SEC_SEL_RST;
            ack_mode_q <= idedec_pkg::ACK_MODE_RST;
            wide_pin_q <= idedec_pkg::WIDE_PIN_RST;
        end else if (clk_en) begin
            ide_en_q   <= ide_enable;
            sec_q      <= secondary_base;
            ack_mode_q <= function_ctrl_reg[idedec_pkg::FUNC_ACK_BIT];
            wide_pin_q <= ~alternate_setup_reg[idedec_pkg::ALT_WIDE_BIT];
        end
    end

    // ----------------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------------
    // raw window hits, one per base and block
    logic hit_cmd_pri;
    logic hit_cmd_sec;
    logic hit_ctl_pri;
    logic hit_ctl_sec;

    idedec_decode #(
        .MASK_BITS (idedec_pkg::CMD_MASK_BITS),
        .BASE      (idedec_pkg::CMD_PRI_BASE)
    ) u_cmd_pri (
        .addr (host_addr),
        .hit  (hit_cmd_pri)
    );

    idedec_decode #(
        .MASK_BITS (idedec_pkg::CMD_MASK_BITS),
        .BASE      (idedec_pkg::CMD_SEC_BASE)
    ) u_cmd_sec (
        .addr (host_addr),
        .hit  (hit_cmd_sec)
    );

    idedec_decode #(
        .MASK_BITS (idedec_pkg::CTRL_MASK_BITS),
        .BASE      (idedec_pkg::CTRL_PRI_LO)
    ) u_ctl_pri (
        .addr (host_addr),
        .hit  (hit_ctl_pri)
    );

    idedec_decode #(
        .MASK_BITS (idedec_pkg::CTRL_MASK_BITS),
        .BASE      (idedec_pkg::CTRL_SEC_LO)
    ) u_ctl_sec (
        .addr (host_addr),
        .hit  (hit_ctl_sec)
    );

    // base-selected hits and strobe-qualified access
    logic cmd_hit;
    logic ctl_hit;
    logic ctl_hi_addr;
    logic access;

    // select the active base, gate with enable and a live strobe
    assign cmd_hit = sec_q ? hit_cmd_sec : hit_cmd_pri;
    assign ctl_hit = sec_q ? hit_ctl_sec : hit_ctl_pri;
    assign ctl_hi_addr = (host_addr == (sec_q ? idedec_pkg::CTRL_SEC_HI
                                              : idedec_pkg::CTRL_PRI_HI));
    assign access  = ide_en_q & (~host_rd_n | ~host_wr_n);

    // ----------------------------------------------------------------------
    // chip selects and byte latch enables
    // ----------------------------------------------------------------------
    // selects decode the address alone, so they lead the strobe
    // and give the drive its setup before the latches open
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            drive_cmd_block_select_n  <= idedec_pkg::SEL_N_RST;
            drive_ctrl_block_select_n <= idedec_pkg::SEL_N_RST;
        end else if (clk_en) begin
            drive_cmd_block_select_n  <= ~(ide_en_q & cmd_hit);
            drive_ctrl_block_select_n <= ~(ide_en_q & ctl_hit);
        end
    end

    // latch enables follow drive accesses; high byte needs the wide select
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            low_byte_latch_en_n  <= idedec_pkg::LATCH_N_RST;
            high_byte_latch_en_n <= idedec_pkg::LATCH_N_RST;
        end else if (clk_en) begin
            low_byte_latch_en_n  <= ~(access & (cmd_hit | ctl_hit));
            high_byte_latch_en_n <= ~(access & (cmd_hit | ctl_hit)
                                      & wide_pin_q & ~wide_transfer_select_in_n);
        end
    end

    // ----------------------------------------------------------------------
    // data bit 7 steering
    // ----------------------------------------------------------------------
    // bit 7 follows the command block and the low control address
    logic d7_route;
    assign d7_route = access & (cmd_hit | (ctl_hit & ~ctl_hi_addr));

    // drive-side bit 7: driven on routed writes only, floats otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            drive_data_bit7_out <= idedec_pkg::D7_RST;
            drive_data_bit7_oe  <= idedec_pkg::D7_RST;
        end else if (clk_en) begin
            drive_data_bit7_out <= host_d7_out;
            drive_data_bit7_oe  <= d7_route & ~host_wr_n & host_d7_oe;
        end
    end

    // host-side bit 7: pin level on routed cycles, low elsewhere
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_d7_in <= idedec_pkg::D7_RST;
        end else if (clk_en) begin
            host_d7_in <= d7_route ? drive_data_bit7_in : 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // shared pin, identity strap and density polarity
    // ----------------------------------------------------------------------
    // strap sequencer state and captured polarity
    idedec_pkg::idedec_state_t st_q;
    logic                      pol_q;

    // capture the identity level once after reset release
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q  <= idedec_pkg::IDEDEC_ST_RESET;
            pol_q <= idedec_pkg::POL_RST;
        end else if (clk_en) begin
            case (st_q)
                idedec_pkg::IDEDEC_ST_RESET: st_q <= idedec_pkg::IDEDEC_ST_LATCH;
                idedec_pkg::IDEDEC_ST_LATCH: begin
                    pol_q <= ack_mode_q ? 1'b1 : drive_dma_ack_in;
                    st_q  <= idedec_pkg::IDEDEC_ST_RUN;
                end
                idedec_pkg::IDEDEC_ST_RUN: begin
                    if (ack_mode_q) begin
                        pol_q <= 1'b1;
                    end
                end
                default: st_q <= idedec_pkg::IDEDEC_ST_RESET;
            endcase
        end
    end

    // density output, polarity applied to the raw rate
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            density_select_out <= idedec_pkg::DENS_RST;
        end else if (clk_en) begin
            density_select_out <= pol_q ? fast_rate : ~fast_rate;
        end
    end

    // dma ack passes through only while the shared pin is in ack mode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ide_dma_ack_n <= idedec_pkg::ACK_N_RST;
        end else if (clk_en) begin
            ide_dma_ack_n <= ack_mode_q ? drive_dma_ack_in : 1'b1;
        end
    end
endmodule : idedec_top

// ### test/idedec_drv.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// drive model
// ------------------------------------------------------------
module idedec_drv (
    // clock
    input  wire logic ref_clk,
    // pins from the decoder
    input  wire logic cmd_sel_n,
    input  wire logic ctrl_sel_n,
    input  wire logic d7_oe,
    input  wire logic d7_out,
    // bench controls and drive pins
    input  wire logic wide_cap,
    input  wire logic d7_val,
    output logic      wide_n,
    output logic      d7_in
);
    logic last_q = 1'b0;
    // released bit flips every cycle
    always_ff @(posedge ref_clk) last_q <= d7_in;
    // wide select only from a capable drive
    assign wide_n = ~wide_cap;
    assign d7_in  = d7_oe ? d7_out : (!cmd_sel_n || !ctrl_sel_n) ? d7_val : ~last_q;
endmodule : idedec_drv

// ### test/idedec_chk_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module idedec_chk (
    // clock, host address and configuration
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic [9:0] host_addr,
    input wire logic       ide_enable,
    input wire logic       secondary_base,
    input wire logic [7:0] function_ctrl_reg,
    input wire logic       fast_rate,
    // drive side, density and dma ack
    input wire logic       wide_transfer_select_in_n,
    input wire logic       drive_data_bit7_oe,
    input wire logic       drive_cmd_block_select_n,
    input wire logic       drive_ctrl_block_select_n,
    input wire logic       low_byte_latch_en_n,
    input wire logic       high_byte_latch_en_n,
    input wire logic       density_select_out,
    input wire logic       ide_dma_ack_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // selects after a steady address
    a_cmd_primary: assert property (
        (clk_en && ide_enable && !secondary_base && host_addr[9:3] == 7'h3e) [*3]
        |=> !drive_cmd_block_select_n) else $error("command select missing");
    a_cmd_secondary: assert property (
        (clk_en && ide_enable && secondary_base && host_addr[9:3] == 7'h2e) [*3]
        |=> !drive_cmd_block_select_n) else $error("secondary command select missing");
    a_ctrl_primary: assert property (
        (clk_en && ide_enable && !secondary_base && host_addr[9:1] == 9'h1fb) [*3]
        |=> !drive_ctrl_block_select_n) else $error("primary control select missing");
    a_ctrl_secondary: assert property (
        (clk_en && ide_enable && secondary_base && host_addr == 10'h376) [*3]
        |=> !drive_ctrl_block_select_n) else $error("control select missing");
    // disabled interface
    a_sel_disabled: assert property (
        (clk_en && !ide_enable) [*3]
        |=> drive_cmd_block_select_n && drive_ctrl_block_select_n)
        else $error("select while disabled");
    a_latch_disabled: assert property (
        (clk_en && !ide_enable) [*3] |=> low_byte_latch_en_n && high_byte_latch_en_n)
        else $error("latch enable while disabled");
    // high byte and bit 7
    a_hi_wide: assert property (
        !high_byte_latch_en_n && $past(clk_en) |-> !$past(wide_transfer_select_in_n))
        else $error("high latch without wide select");
    a_oe_float: assert property (
        $past(clk_en) && ($past(host_addr) == 10'h3f7 || $past(host_addr) == 10'h377)
        |-> !drive_data_bit7_oe) else $error("bit 7 driven at upper control");
    // shared pin
    a_ack_ident: assert property (
        (clk_en && !function_ctrl_reg[1]) [*3] |=> ide_dma_ack_n)
        else $error("ack in identity mode");
    a_dens_ack: assert property (
        (clk_en && function_ctrl_reg[1] && fast_rate) [*3] |=> density_select_out)
        else $error("density not active high");
endmodule : idedec_chk

bind idedec_top idedec_chk u_chk (
    .ref_clk                   (ref_clk),
    .reset                     (reset),
    .clk_en                    (clk_en),
    .host_addr                 (host_addr),
    .ide_enable                (ide_enable),
    .secondary_base            (secondary_base),
    .function_ctrl_reg         (function_ctrl_reg),
    .fast_rate                 (fast_rate),
    .wide_transfer_select_in_n (wide_transfer_select_in_n),
    .drive_data_bit7_oe        (drive_data_bit7_oe),
    .drive_cmd_block_select_n  (drive_cmd_block_select_n),
    .drive_ctrl_block_select_n (drive_ctrl_block_select_n),
    .low_byte_latch_en_n       (low_byte_latch_en_n),
    .high_byte_latch_en_n      (high_byte_latch_en_n),
    .density_select_out        (density_select_out),
    .ide_dma_ack_n             (ide_dma_ack_n)
);

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // pins, counters and rows
    // ------------------------------------------------------------
    logic       ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, ide_enable = 1'b1;
    logic       host_rd_n = 1'b1, host_wr_n = 1'b1, host_d7_out = 1'b1, host_d7_oe = 1'b0;
    logic       secondary_base = 1'b0, fast_rate = 1'b1, drive_dma_ack_in = 1'b1;
    logic       wide_cap = 1'b0, d7_val = 1'b1;
    logic [9:0] host_addr = 10'h000;
    logic [7:0] function_ctrl_reg = 8'h00, alternate_setup_reg = 8'h00;
    logic       host_d7_in, drive_data_bit7_out, drive_data_bit7_oe, density_select_out;
    logic       drive_cmd_block_select_n, drive_ctrl_block_select_n, ide_dma_ack_n;
    logic       low_byte_latch_en_n, high_byte_latch_en_n;
    wire logic  wide_transfer_select_in_n, drive_data_bit7_in;
    wire logic [5:0] outs = {drive_cmd_block_select_n, drive_ctrl_block_select_n,
        low_byte_latch_en_n, high_byte_latch_en_n, drive_data_bit7_oe, host_d7_in};
    int         fail_count = 0, samples_checked = 0, cycles = 0;
    // address, rd_n wr_n secondary capable, cmd ctrl lo hi oe d7
    logic [19:0] rows [12] = '{
        {10'h1f0, 4'h9, 6'h13}, {10'h1f7, 4'h4, 6'h15}, {10'h1f8, 4'h8, 6'h3c},
        {10'h3f6, 4'h9, 6'h23}, {10'h3f7, 4'h4, 6'h24}, {10'h170, 4'h7, 6'h11},
        {10'h177, 4'ha, 6'h17}, {10'h376, 4'h6, 6'h25}, {10'h377, 4'ha, 6'h24},
        {10'h1f0, 4'ha, 6'h3c}, {10'h16f, 4'h6, 6'h3c}, {10'h1f2, 4'hc, 6'h1c}};

    idedec_top dut (
        .ref_clk                   (ref_clk),
        .reset                     (reset),
        .clk_en                    (clk_en),
        .host_addr                 (host_addr),
        .host_rd_n                 (host_rd_n),
        .host_wr_n                 (host_wr_n),
        .host_d7_out               (host_d7_out),
        .host_d7_oe                (host_d7_oe),
        .host_d7_in                (host_d7_in),
        .ide_enable                (ide_enable),
        .secondary_base            (secondary_base),
        .function_ctrl_reg         (function_ctrl_reg),
        .alternate_setup_reg       (alternate_setup_reg),
        .fast_rate                 (fast_rate),
        .wide_transfer_select_in_n (wide_transfer_select_in_n),
        .drive_dma_ack_in          (drive_dma_ack_in),
        .drive_data_bit7_in        (drive_data_bit7_in),
        .drive_data_bit7_out       (drive_data_bit7_out),
        .drive_data_bit7_oe        (drive_data_bit7_oe),
        .drive_cmd_block_select_n  (drive_cmd_block_select_n),
        .drive_ctrl_block_select_n (drive_ctrl_block_select_n),
        .low_byte_latch_en_n       (low_byte_latch_en_n),
        .high_byte_latch_en_n      (high_byte_latch_en_n),
        .density_select_out        (density_select_out),
        .ide_dma_ack_n             (ide_dma_ack_n)
    );
    idedec_drv drv (.ref_clk, .cmd_sel_n(drive_cmd_block_select_n),
        .ctrl_sel_n(drive_ctrl_block_select_n), .d7_oe(drive_data_bit7_oe),
        .d7_out(drive_data_bit7_out), .wide_cap, .d7_val(d7_val),
        .wide_n(wide_transfer_select_in_n), .d7_in(drive_data_bit7_in));

    // clock and hang guard
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 400) begin
            fail_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task run_row(input logic [19:0] r);
        {host_addr, host_rd_n, host_wr_n, secondary_base, wide_cap} = r[19:6];
        host_d7_oe = ~r[8];
        repeat (3) @(negedge ref_clk);
        check("decode", {2'b00, outs}, {2'b00, r[5:0]});
    endtask : run_row
    task do_reset(input logic pin);
        drive_dma_ack_in = pin;
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("reset", {outs, density_select_out, ide_dma_ack_n}, 8'hf1);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : do_reset
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        foreach (rows[i]) run_row(rows[i]);
        check("bit 7 out", {7'h00, drive_data_bit7_out}, 8'h01);
        alternate_setup_reg = 8'h04;
        run_row({10'h1f0, 4'h9, 6'h17});
        alternate_setup_reg = 8'h00;
        ide_enable = 1'b0;
        run_row({10'h1f0, 4'h9, 6'h3c});
        ide_enable = 1'b1;
        run_row({10'h1f0, 4'h9, 6'h13});
        // frozen outputs hold while address moves
        clk_en = 1'b0;
        run_row({10'h16f, 4'h9, 6'h13});
        clk_en = 1'b1;
        // low bit 7 level through a write and a read
        host_d7_out = 1'b0;
        d7_val = 1'b0;
        run_row({10'h1f3, 4'h9, 6'h12});
        check("bit 7 out", {7'h00, drive_data_bit7_out}, 8'h00);
        run_row({10'h3f6, 4'h4, 6'h24});
        host_d7_out = 1'b1;
        d7_val = 1'b1;
        // strap level and shared pin function
        do_reset(1'b0);
        check("density", {6'h00, density_select_out, ide_dma_ack_n}, 8'h01);
        function_ctrl_reg = 8'h02;
        repeat (3) @(negedge ref_clk);
        check("dma ack", {6'h00, density_select_out, ide_dma_ack_n}, 8'h02);
        drive_dma_ack_in = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("dma ack", {6'h00, density_select_out, ide_dma_ack_n}, 8'h03);
        function_ctrl_reg = 8'h00;
        do_reset(1'b1);
        check("density", {6'h00, density_select_out, ide_dma_ack_n}, 8'h03);
        test_done();
    end
endmodule : tb
